/* design/fbp_defines.svh */
// Constants for the second-bank flash protect and program/erase controller
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// Register byte offsets (word aligned); array window selected by address bit 16
`define FBP_OFS_CONTROL      16'h0000
`define FBP_OFS_PROTECT      16'h0004
`define FBP_OFS_STATUS       16'h0008
`define FBP_ARRAY_SEL_BIT    16

// Control register fields
`define FBP_BIT_PGM          0
`define FBP_BIT_ERASE        1
`define FBP_BIT_MASS         2
`define FBP_BIT_HIGH_VOLTAGE_ENABLE         3

// Status register fields
`define FBP_ST_STATE_LSB     0
`define FBP_ST_STATE_MSB     4
`define FBP_BIT_ROW_FAIL     5
`define FBP_BIT_REFUSED      6
`define FBP_BIT_NVS_DONE     7
`define FBP_BIT_STANDBY      8

// Protect decode
`define FBP_PROT_NONE        8'hff
`define FBP_PROT_CLAMP_MAX   8'h08
`define FBP_ARRAY_FIRST      16'h0462
`define FBP_ARRAY_LAST       16'h7fff
`define FBP_PAGE_BITS        7
`define FBP_ROW_BITS         6
`define FBP_ROW_DEPTH        64
`define FBP_PROT_RESET       8'h00

// Timing: least non-volatile setup time before high voltage may be set
`define FBP_CLK_PERIOD_NS    5
`define FBP_T_NVS_NS         10000
`define FBP_NVS_CYCLES       ((`FBP_T_NVS_NS + `FBP_CLK_PERIOD_NS - 1) / `FBP_CLK_PERIOD_NS)
`define FBP_NVS_W            12

`endif

/* design/fbp_pkg.sv */
// Types shared by the flash protect and program/erase controller
package fbp_pkg;

	typedef enum logic [4:0] {
		FBP_IDLE    = 5'h01,
		FBP_ARMED   = 5'h02,
		FBP_CHECKED = 5'h04,
		FBP_LATCHED = 5'h08,
		FBP_HV      = 5'h10
	} fbp_state_t;

	typedef logic [15:0] fbp_addr_t;
	typedef logic [7:0]  fbp_byte_t;

endpackage

/* design/fbp_prot_decode.sv */
// Protect start address decode and range compare
`timescale 1ns/1ps
`include "fbp_defines.svh"

module fbp_prot_decode (
	input  wire logic            [7:0] prot_value_in,
	input  wire fbp_pkg::fbp_addr_t    addr_in,
	output      fbp_pkg::fbp_addr_t    start_addr_out,
	output      logic                  protected_out
);
	import fbp_pkg::*;

	fbp_addr_t raw_start;

	always_comb begin
		// Value supplies address bits 14..7; 15 and 6..0 are zero
		raw_start = {1'b0, prot_value_in, {`FBP_PAGE_BITS{1'b0}}};
		// Low values clamp to the first array location
		if (prot_value_in <= `FBP_PROT_CLAMP_MAX) begin
			start_addr_out = `FBP_ARRAY_FIRST;
		end else begin
			start_addr_out = raw_start;
		end
		// Range runs to the bank top; all ones protects nothing, holes ignored
		protected_out = (prot_value_in != `FBP_PROT_NONE) &&
			(addr_in >= start_addr_out) && (addr_in <= `FBP_ARRAY_LAST);
	end

endmodule

/* design/fbp_row_buffer.sv */
// One-row program data buffer with registered read data
`timescale 1ns/1ps
`include "fbp_defines.svh"

module fbp_row_buffer (
	input  wire logic                       core_clk_in,
	input  wire logic                       wr_en_in,
	input  wire logic [`FBP_ROW_BITS-1:0]   wr_addr_in,
	input  wire fbp_pkg::fbp_byte_t         wr_data_in,
	input  wire logic [`FBP_ROW_BITS-1:0]   rd_addr_in,
	output      fbp_pkg::fbp_byte_t         rd_data_out
);
	import fbp_pkg::*;

	fbp_byte_t mem [`FBP_ROW_DEPTH];

	always_ff @(posedge core_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// Write-through so the byte being programmed appears next cycle
	always_ff @(posedge core_clk_in) begin
		if (wr_en_in) begin
			rd_data_out <= wr_data_in;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end

endmodule

/* design/fbp_flash_ctrl.sv */
// Second-bank flash controller: protect decode, program/erase sequencing, APB slave
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_flash_ctrl (
	input  wire logic                core_clk_in,
	input  wire logic                rstn_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [16:0]         paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output      logic [31:0]         prdata_out,
	output      logic                pready_out,
	output      logic                pslverr_out,
	input  wire logic [7:0]          prot_value_in,
	input  wire logic                prot_reload_in,
	input  wire logic                vector_erase_in,
	input  wire logic                wait_mode_in,
	input  wire logic                stop_mode_in,
	output      logic                array_prog_out,
	output      logic                array_erase_out,
	output      logic                array_mass_out,
	output      logic                high_voltage_out,
	output      fbp_pkg::fbp_addr_t  array_addr_out,
	output      fbp_pkg::fbp_byte_t  array_data_out,
	output      logic                array_wr_out,
	output      logic                standby_out
);
	import fbp_pkg::*;
	fbp_state_t             state, next_state;
	logic                   program_select, erase, mass, high_voltage_enable;
	logic                   next_program_select, next_erase, next_mass, next_high_voltage_enable;
	logic [7:0]             bank2_protect_start;
	fbp_addr_t              latched_addr, prot_start;
	logic                   prot_loaded, target_protected, hv_blocked, hv_request;
	logic                   hv_accept, interlock_refuse, nvs_done, row_fail, refused;
	logic [`FBP_NVS_W-1:0]  nvs_count;
	logic                   low_power, acc, wr, rd, is_array, sel_ctrl, sel_prot, sel_stat;
	logic                   arr_wr, byte_write, row_miss;
	fbp_byte_t              row_rdata;
	logic [31:0]            rd_word;
	function automatic logic [9:0] row_of(input fbp_addr_t a);
		row_of = a[15:`FBP_ROW_BITS];
	endfunction
	function automatic logic [15:0] reg_ofs(input logic [16:0] a);
		reg_ofs = a[15:0];
	endfunction
	// APB decode; the transfer completes at the edge where pready is high
	assign acc      = psel_in && penable_in && pready_out;
	assign wr       = acc && pwrite_in;
	assign rd       = acc && !pwrite_in;
	assign is_array = paddr_in[`FBP_ARRAY_SEL_BIT];
	assign sel_ctrl = !is_array && (reg_ofs(paddr_in) == `FBP_OFS_CONTROL);
	assign sel_prot = !is_array && (reg_ofs(paddr_in) == `FBP_OFS_PROTECT);
	assign sel_stat = !is_array && (reg_ofs(paddr_in) == `FBP_OFS_STATUS);
	assign arr_wr   = wr && is_array;
	assign low_power = wait_mode_in || stop_mode_in;
	fbp_prot_decode u_decode (
		.prot_value_in  (bank2_protect_start),
		.addr_in        (latched_addr),
		.start_addr_out (prot_start),
		.protected_out  (target_protected)
	);
	// Mass erase needs a fully unprotected bank, otherwise the target decides
	assign hv_blocked = (erase && mass) ? (bank2_protect_start != `FBP_PROT_NONE)
		: target_protected;
	assign hv_request = wr && sel_ctrl && pwdata_in[`FBP_BIT_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable;
	assign hv_accept  = hv_request && (state == FBP_LATCHED) && nvs_done && !hv_blocked
		&& (program_select || erase);
	assign interlock_refuse = wr && sel_ctrl && pwdata_in[`FBP_BIT_PGM]
		&& pwdata_in[`FBP_BIT_ERASE];
	// Program writes in high voltage must stay inside the latched row
	assign byte_write = arr_wr && (state == FBP_HV) && program_select;
	assign row_miss   = byte_write && (row_of(paddr_in[15:0]) != row_of(latched_addr));
	always_comb begin
		next_program_select = program_select;
		next_erase          = erase;
		next_mass           = mass;
		next_high_voltage_enable           = high_voltage_enable;
		if (wr && sel_ctrl) begin
			// Both requested at once: keep the present selection
			if (!interlock_refuse) begin
				next_program_select = pwdata_in[`FBP_BIT_PGM];
				next_erase          = pwdata_in[`FBP_BIT_ERASE];
			end
			next_mass = pwdata_in[`FBP_BIT_MASS];
			if (!pwdata_in[`FBP_BIT_HIGH_VOLTAGE_ENABLE]) begin
				next_high_voltage_enable = 1'b0;
			end else if (hv_accept) begin
				next_high_voltage_enable = 1'b1;
			end
		end
	end
	// Control bits; reset leaves no high-voltage operation active
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			program_select      <= 1'b0;
			erase               <= 1'b0;
			mass                <= 1'b0;
			high_voltage_enable <= 1'b0;
		end else begin
			program_select      <= next_program_select;
			erase               <= next_erase;
			mass                <= next_mass;
			high_voltage_enable <= next_high_voltage_enable;
		end
	end
	// Sequence tracker: select, protect read, latch write, then high voltage
	always_comb begin
		next_state = state;
		case (state)
			FBP_IDLE: begin
				if (next_program_select || next_erase) begin
					next_state = FBP_ARMED;
				end
			end
			FBP_ARMED: begin
				if (rd && sel_prot) begin
					next_state = FBP_CHECKED;
				end
			end
			FBP_CHECKED: begin
				if (arr_wr) begin
					next_state = FBP_LATCHED;
				end
			end
			FBP_LATCHED: begin
				if (next_high_voltage_enable) begin
					next_state = FBP_HV;
				end
			end
			FBP_HV: begin
				if (!next_high_voltage_enable) begin
					next_state = FBP_IDLE;
				end
			end
			default: begin
				next_state = FBP_IDLE;
			end
		endcase
		if (state != FBP_HV && !next_program_select && !next_erase) begin
			next_state = FBP_IDLE;
		end
	end
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= FBP_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// First array write after the protect read latches the target
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			latched_addr <= `FBP_ARRAY_FIRST;
		end else if (state == FBP_CHECKED && arr_wr) begin
			latched_addr <= paddr_in[15:0];
		end
	end
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nvs_count <= '0;
		end else if (state != FBP_LATCHED) begin
			nvs_count <= '0;
		end else if (!nvs_done) begin
			nvs_count <= nvs_count + 1'b1;
		end
	end
	assign nvs_done = (nvs_count >= `FBP_NVS_W'(`FBP_NVS_CYCLES));
	// Protect value copy; taken after reset, reloaded on request
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bank2_protect_start <= `FBP_PROT_RESET;
			prot_loaded         <= 1'b0;
		end else begin
			prot_loaded <= 1'b1;
			if (vector_erase_in) begin
				bank2_protect_start <= `FBP_PROT_NONE;
			end else if (!prot_loaded || prot_reload_in) begin
				bank2_protect_start <= prot_value_in;
			end
		end
	end
	// Sticky error flags; a new event wins over a write-one clear
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			row_fail <= 1'b0;
			refused  <= 1'b0;
		end else begin
			if (row_miss) begin
				row_fail <= 1'b1;
			end else if (wr && sel_stat && pwdata_in[`FBP_BIT_ROW_FAIL]) begin
				row_fail <= 1'b0;
			end
			if ((hv_request && !hv_accept) || interlock_refuse) begin
				refused <= 1'b1;
			end else if (wr && sel_stat && pwdata_in[`FBP_BIT_REFUSED]) begin
				refused <= 1'b0;
			end
		end
	end
	fbp_row_buffer u_row (
		.core_clk_in (core_clk_in),
		.wr_en_in    (byte_write && !row_miss),
		.wr_addr_in  (paddr_in[`FBP_ROW_BITS-1:0]),
		.wr_data_in  (pwdata_in[7:0]),
		.rd_addr_in  (paddr_in[`FBP_ROW_BITS-1:0]),
		.rd_data_out (row_rdata)
	);
	// Array drive; wait or stop forces standby with controls inactive
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			array_prog_out   <= 1'b0;
			array_erase_out  <= 1'b0;
			array_mass_out   <= 1'b0;
			high_voltage_out <= 1'b0;
			array_wr_out     <= 1'b0;
			array_addr_out   <= `FBP_ARRAY_FIRST;
			standby_out      <= 1'b0;
		end else begin
			array_prog_out   <= program_select && !low_power;
			array_erase_out  <= erase && !low_power;
			array_mass_out   <= erase && mass && !low_power;
			high_voltage_out <= high_voltage_enable && !low_power;
			array_wr_out     <= byte_write && !row_miss && !low_power;
			standby_out      <= low_power;
			if ((byte_write && !row_miss) || (state == FBP_CHECKED && arr_wr)) begin
				array_addr_out <= paddr_in[15:0];
			end
		end
	end
	assign array_data_out = row_rdata;
	always_comb begin
		rd_word = '0;
		if (is_array) begin
			rd_word[7:0] = row_rdata;
		end else if (sel_ctrl) begin
			rd_word[`FBP_BIT_PGM]   = program_select;
			rd_word[`FBP_BIT_ERASE] = erase;
			rd_word[`FBP_BIT_MASS]  = mass;
			rd_word[`FBP_BIT_HIGH_VOLTAGE_ENABLE]  = high_voltage_enable;
		end else if (sel_prot) begin
			rd_word[7:0] = bank2_protect_start;
		end else if (sel_stat) begin
			rd_word[`FBP_ST_STATE_MSB:`FBP_ST_STATE_LSB] = state;
			rd_word[`FBP_BIT_ROW_FAIL] = row_fail;
			rd_word[`FBP_BIT_REFUSED]  = refused;
			rd_word[`FBP_BIT_NVS_DONE] = nvs_done;
			rd_word[`FBP_BIT_STANDBY]  = low_power;
		end
	end
	// One wait state; read data and error are registered with pready
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= '0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in && penable_in && !pready_out;
			if (psel_in && penable_in && !pready_out) begin
				prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_word;
				pslverr_out <= !is_array && !sel_ctrl && !sel_prot && !sel_stat;
			end else begin
				pslverr_out <= 1'b0;
			end
		end
	end
	sequence seq_setup;
		psel_in && !penable_in;
	endsequence
	sequence seq_access;
		psel_in && penable_in && !pready_out;
	endsequence
	chk_apb_wait: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		seq_setup ##1 seq_access |=> pready_out)
		else $error("APB access not answered after one wait state");
	chk_interlock_excl: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		!(program_select && erase))
		else $error("Program and erase selected together");
	chk_hv_sequence: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		$rose(high_voltage_enable) |-> $past(state) == FBP_LATCHED && $past(nvs_done))
		else $error("High voltage set outside the proper sequence");
	chk_hv_protect: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		$rose(high_voltage_enable) |-> !$past(hv_blocked))
		else $error("High voltage set on protected target");
	chk_mass_lock: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		$rose(high_voltage_enable) && erase && mass |->
			$past(bank2_protect_start) == `FBP_PROT_NONE)
		else $error("Mass erase started while protected");
	chk_standby_off: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		low_power |=> standby_out && !high_voltage_out && !array_prog_out
			&& !array_erase_out && !array_wr_out)
		else $error("Array controls active in standby");
	chk_vector_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		vector_erase_in |=> bank2_protect_start == `FBP_PROT_NONE)
		else $error("Vector page erase left protect value");
	chk_start_clamp: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		bank2_protect_start <= `FBP_PROT_CLAMP_MAX |-> prot_start == `FBP_ARRAY_FIRST)
		else $error("Low protect value not clamped");
	chk_start_decode: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		bank2_protect_start > `FBP_PROT_CLAMP_MAX |->
			prot_start == {1'b0, bank2_protect_start, 7'h00})
		else $error("Protect start address misdecoded");
	chk_row_fail: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		row_miss |=> row_fail && !array_wr_out)
		else $error("Cross-row program write not flagged");

endmodule

/* bench/fbp_cpu_model.sv */
// CPU-side APB master model that runs the flash control sequences
`timescale 1ns/1ps
module fbp_cpu_model (
	input  wire logic        core_clk_in,
	output      logic        psel_out,
	output      logic        penable_out,
	output      logic        pwrite_out,
	output      logic [16:0] paddr_out,
	output      logic [31:0] pwdata_out,
	input  wire logic [31:0] prdata_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 17'h0;
		pwdata_out = 32'h0;
	end

	// One APB transfer; request held until pready is seen at an edge
	task automatic xfer(input logic wr, input logic [16:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge core_clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= addr;
		pwdata_out <= wdata;
		@(posedge core_clk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge core_clk_in);
		end while (pready_in !== 1'b1);
		rdata = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
	endtask

	// Select operation, read protect, latch target, then wait out setup time
	task automatic arm(input logic [31:0] mode, input logic [15:0] addr);
		logic [31:0] d;
		logic        e;
		xfer(1'b1, 17'h0, mode, d, e);
		xfer(1'b0, 17'h4, 32'h0, d, e);
		xfer(1'b1, {1'b1, addr}, {24'h0, 8'($urandom)}, d, e);
		do begin
			xfer(1'b0, 17'h8, 32'h0, d, e);
		end while (d[7] !== 1'b1);
	endtask
endmodule

/* bench/tb_flash_bank_protect_program_erase.sv */
// Self-checking testbench for the second-bank flash controller
`timescale 1ns/1ps
module tb_flash_bank_protect_program_erase;
	import fbp_pkg::*;
	logic               core_clk_in = 1'b0;
	logic               rstn_in = 1'b0;
	logic [7:0]         prot_value_in = 8'hff;
	logic               prot_reload_in = 1'b0;
	logic               vector_erase_in = 1'b0;
	logic               wait_mode_in = 1'b0;
	logic               stop_mode_in = 1'b0;
	logic               psel, penable, pwrite, pready, pslverr;
	logic [16:0]        paddr;
	logic [31:0]        pwdata, prdata;
	logic               array_prog_out, array_erase_out, array_mass_out;
	logic               high_voltage_out, array_wr_out, standby_out;
	fbp_addr_t          array_addr_out, seen_addr;
	fbp_byte_t          array_data_out, seen_data;
	int                 errors = 0;
	int                 n_tests = 0;
	int                 wr_cnt = 0;
	logic [31:0]        cases [13] = '{32'hff7fff02, 32'hfe7eff02, 32'hfe7f0001,
		32'hfd7e8002, 32'hfd7e7f01, 32'h09048002, 32'h09047f01, 32'h08046202,
		32'h00046201, 32'hff046206, 32'hfe046206, 32'h0b058002, 32'h0a04ff01};

	always #2.5 core_clk_in = ~core_clk_in;

	fbp_flash_ctrl dut (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .prot_value_in(prot_value_in),
		.prot_reload_in(prot_reload_in), .vector_erase_in(vector_erase_in),
		.wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in),
		.array_prog_out(array_prog_out), .array_erase_out(array_erase_out),
		.array_mass_out(array_mass_out), .high_voltage_out(high_voltage_out),
		.array_addr_out(array_addr_out), .array_data_out(array_data_out),
		.array_wr_out(array_wr_out), .standby_out(standby_out)
	);

	fbp_cpu_model cpu (
		.core_clk_in(core_clk_in), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
		.prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr)
	);

	// Capture each programmed byte handed to the array
	always @(posedge core_clk_in) begin
		if (array_wr_out === 1'b1) begin
			wr_cnt++;
			seen_addr = array_addr_out;
			seen_data = array_data_out;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic exp_blocked(input logic [7:0] v, input logic [15:0] a,
		input logic mass);
		logic [15:0] start;
		start = (v <= 8'h08) ? 16'h0462 : {1'b0, v, 7'h00};
		if (mass)
			return v != 8'hff;
		return v != 8'hff && a >= start && a <= 16'h7fff;
	endfunction

	task automatic set_prot(input logic [7:0] v);
		@(posedge core_clk_in);
		prot_value_in <= v;
		prot_reload_in <= 1'b1;
		@(posedge core_clk_in);
		prot_reload_in <= 1'b0;
		@(posedge core_clk_in);
	endtask

	// Full sequence up to high voltage, then program or low-power checks
	task automatic try_hv(input logic [7:0] v, input logic [15:0] a, input logic [7:0] mode);
		logic        blk;
		logic [31:0] d;
		logic        e;
		logic [15:0] pa;
		logic [7:0]  b;
		blk = exp_blocked(v, a, mode == 8'h06);
		set_prot(v);
		cpu.arm({24'h0, mode}, a);
		cpu.xfer(1'b1, 17'h0, {24'h0, mode | 8'h08}, d, e);
		cpu.xfer(1'b0, 17'h0, 32'h0, d, e);
		chk("ctrl", {24'h0, blk ? mode : (mode | 8'h08)}, d);
		cpu.xfer(1'b0, 17'h8, 32'h0, d, e);
		chk("state", blk ? 32'h8 : 32'h10, {27'h0, d[4:0]});
		chk1("refused", blk, d[6]);
		chk1("hv_out", !blk, high_voltage_out);
		chk1("mass_out", mode == 8'h06, array_mass_out);
		chk1("prog_out", mode == 8'h01, array_prog_out);
		if (!blk && mode == 8'h01) begin
			pa = {a[15:6], 6'($urandom)};
			b = 8'($urandom);
			wr_cnt = 0;
			cpu.xfer(1'b1, {1'b1, pa}, {24'h0, b}, d, e);
			repeat (2) @(posedge core_clk_in);
			chk("wr_count", 32'd1, wr_cnt);
			chk("wr_addr", {16'h0, pa}, {16'h0, seen_addr});
			chk("wr_data", {24'h0, b}, {24'h0, seen_data});
			cpu.xfer(1'b1, {1'b1, pa ^ 16'h0040}, 32'h0, d, e);
			cpu.xfer(1'b0, 17'h8, 32'h0, d, e);
			chk1("row_fail", 1'b1, d[5]);
			chk("wr_count2", 32'd1, wr_cnt);
			cpu.xfer(1'b0, {1'b1, pa}, 32'h0, d, e);
			chk("arr_read", {24'h0, b}, d);
		end else if (!blk) begin
			@(posedge core_clk_in);
			if (mode == 8'h02)
				wait_mode_in <= 1'b1;
			else
				stop_mode_in <= 1'b1;
			repeat (3) @(posedge core_clk_in);
			chk1("lp_hv", 1'b0, high_voltage_out);
			chk1("lp_erase", 1'b0, array_erase_out);
			chk1("standby", 1'b1, standby_out);
			wait_mode_in <= 1'b0;
			stop_mode_in <= 1'b0;
			repeat (3) @(posedge core_clk_in);
			chk1("resume_hv", 1'b1, high_voltage_out);
		end
		cpu.xfer(1'b1, 17'h0, 32'h08, d, e);
		cpu.xfer(1'b1, 17'h0, 32'h00, d, e);
		cpu.xfer(1'b1, 17'h8, 32'h60, d, e);
		cpu.xfer(1'b0, 17'h8, 32'h0, d, e);
		chk("idle", 32'h1, {27'h0, d[4:0]});
		chk1("idle_hv", 1'b0, high_voltage_out);
	endtask

	initial begin
		logic [31:0] d;
		logic        e;
		logic [7:0]  m;
		void'($urandom(87260));
		repeat (8) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		cpu.xfer(1'b0, 17'h0, 32'h0, d, e);
		chk("ctrl_reset", 32'h0, d);
		chk1("hv_reset", 1'b0, high_voltage_out);
		cpu.xfer(1'b0, 17'h0c, 32'h0, d, e);
		chk1("unmapped_err", 1'b1, e);
		chk("unmapped_data", 32'h0, d);
		set_prot(8'h5a);
		cpu.xfer(1'b0, 17'h4, 32'h0, d, e);
		chk("prot_read", 32'h5a, d);
		cpu.xfer(1'b1, 17'h0, 32'h3, d, e);
		cpu.xfer(1'b0, 17'h0, 32'h0, d, e);
		chk("interlock", 32'h0, d);
		cpu.xfer(1'b1, 17'h0, 32'h8, d, e);
		cpu.xfer(1'b0, 17'h0, 32'h0, d, e);
		chk("hv_alone", 32'h0, d);
		cpu.xfer(1'b0, 17'h8, 32'h0, d, e);
		chk1("refused_flag", 1'b1, d[6]);
		cpu.xfer(1'b1, 17'h8, 32'h60, d, e);
		set_prot(8'h00);
		vector_erase_in <= 1'b1;
		@(posedge core_clk_in);
		vector_erase_in <= 1'b0;
		cpu.xfer(1'b0, 17'h4, 32'h0, d, e);
		chk("vector_erase", 32'hff, d);
		foreach (cases[i])
			try_hv(cases[i][31:24], cases[i][23:8], cases[i][7:0]);
		repeat (12) begin
			m = ($urandom_range(0, 2) == 0) ? 8'h01 : (($urandom_range(0, 1) == 0) ? 8'h02 : 8'h06);
			try_hv(8'($urandom), 16'($urandom_range(16'h0462, 16'h7fff)), m);
		end
		conclude();
	end

	initial begin
		repeat (80000) @(posedge core_clk_in);
		errors++;
		conclude();
	end
endmodule
